/* File: rtl/msb_regs.sv */
// Modem status, bank select, scratch, divisor and FIFO level register logic
//
// Local design decisions: the address map and the plain strobed port.
`include "msb_consts.svh"
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Status and bank select share an address: reads give status, writes set select.
// - Every host read of modem status clears its change bits.
// - Bit 7 is inverted carrier detect, or control bit 3 in loopback.
// - Bit 6 is inverted ring indicator, or control bit 2 in loopback.
// - Bit 5 is inverted data set ready, or control bit 0 in loopback.
// - Bit 4 is inverted clear to send, or control bit 1 in loopback.
// - Bits 3, 1, 0 set on any level change of CD, DSR, CTS.
// - Bit 2 sets only on a ring indicator rise from 0 to 1.
// - Modem status interrupt, with mask bit 0 set, raised on any change bit 3:0 and held until interrupt status is read while change bits 3:0 are clear.
// - Bank select is write only; bits 7:3 are reserved.
// - Bank field 00 general, 01 first extra, 10 second extra, 11 reserved.
// - Select bit 0 makes the level count registers readable.
// - Level counts reachable only when the bank field is zero.
// - Scratch byte stores and returns the host value with no other effect.
// - Divisor high and low bytes form the 16-bit baud divisor.
// - Transmit level count is read only: free transmit FIFO entries.
// - Receive level count is read only: characters held in receive FIFO.
module msb_regs
  import msb_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   srst_i,
  input  wire logic [`MSB_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output var  logic [7:0]             rdata_o,
  input  wire msb_modem_t             modem_n_i,
  input  wire logic [7:0]             tx_space_i,
  input  wire logic [7:0]             rx_fill_i,
  output var  logic [15:0]            divisor_o,
  output var  msb_bank_t              bank_o,
  output var  logic                   lvl_access_o,
  output var  logic [4:0]             modem_ctrl_o,
  output var  logic                   irq_o
);

  logic [4:0]  modem_control_reg;
  msb_sel_t    extra_feature_select;
  logic [7:0]  scratch_byte;
  logic [7:0]  divisor_low;
  logic [7:0]  divisor_high;
  logic [3:0]  prev_in;
  logic [3:0]  delta;
  logic [3:0]  next_delta;
  logic [3:0]  live;
  logic [3:0]  src;
  logic [3:0]  edge_set;
  logic [0:0]  irq_stat;
  logic [0:0]  irq_mask;
  logic        loop;
  logic        lvl_ok;
  logic        rd_modem;
  logic        rd_irq;
  logic        modem_evt;
  logic [7:0]  next_rdata;

  assign loop = modem_control_reg[`MSB_MC_LOOP];
  // Live levels, active high: {cd, ri, dsr, cts}
  always_comb begin
    if (loop) begin
      live = {modem_control_reg[`MSB_MC_OUT2], modem_control_reg[`MSB_MC_OUT1],
              modem_control_reg[`MSB_MC_DTR], modem_control_reg[`MSB_MC_RTS]};
    end else begin
      live = ~modem_n_i;
    end
  end
  assign src = live;

  // Change detect runs on the selected source so loopback also flags changes
  always_comb begin
    edge_set    = 4'h0;
    edge_set[3] = src[3] ^ prev_in[3];
    // Ring pin rising means the active-high live level falls
    edge_set[2] = ~src[2] & prev_in[2];
    edge_set[1] = src[1] ^ prev_in[1];
    edge_set[0] = src[0] ^ prev_in[0];
  end

  assign rd_modem = rd_i && (addr_i == `MSB_OFF_MODEM_STAT);
  assign rd_irq   = rd_i && (addr_i == `MSB_OFF_IRQ_STAT);
  // An edge in the read cycle survives the clear
  always_comb begin
    if (rd_modem) begin
      next_delta = edge_set;
    end else begin
      next_delta = delta | edge_set;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      prev_in <= ~`MSB_RST_MODEM_IN;
      delta   <= 4'h0;
    end else begin
      prev_in <= src;
      delta   <= next_delta;
    end
  end

  // Host writes
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      modem_control_reg    <= 5'h00;
      extra_feature_select <= msb_sel_t'(`MSB_RST_BYTE);
      scratch_byte         <= `MSB_RST_BYTE;
      divisor_low          <= `MSB_RST_BYTE;
      divisor_high         <= `MSB_RST_BYTE;
      irq_mask             <= 1'h0;
    end else if (wr_i) begin
      case (addr_i)
        `MSB_OFF_MODEM_STAT: begin
          extra_feature_select          <= msb_sel_t'(wdata_i);
          extra_feature_select.reserved <= 5'h00;
        end
        `MSB_OFF_SCRATCH:  scratch_byte      <= wdata_i;
        `MSB_OFF_DIV_LOW:  divisor_low       <= wdata_i;
        `MSB_OFF_DIV_HIGH: divisor_high      <= wdata_i;
        `MSB_OFF_MCTRL:    modem_control_reg <= wdata_i[4:0];
        `MSB_OFF_IRQ_MASK: irq_mask          <= wdata_i[0:0];
        default: begin
        end
      endcase
    end
  end

  // Level counts only with bank general and the enable set
  assign lvl_ok = extra_feature_select.lvl_en && (extra_feature_select.bank == MSB_BANK_GEN_E);

  always_comb begin
    case (addr_i)
      `MSB_OFF_MODEM_STAT: next_rdata = {live, delta};
      `MSB_OFF_SCRATCH:    next_rdata = scratch_byte;
      `MSB_OFF_DIV_LOW:    next_rdata = divisor_low;
      `MSB_OFF_DIV_HIGH:   next_rdata = divisor_high;
      `MSB_OFF_MCTRL:      next_rdata = {3'h0, modem_control_reg};
      `MSB_OFF_TX_SPACE:   next_rdata = lvl_ok ? tx_space_i : 8'h00;
      `MSB_OFF_RX_FILL:    next_rdata = lvl_ok ? rx_fill_i : 8'h00;
      `MSB_OFF_IRQ_STAT:   next_rdata = {7'h00, irq_stat};
      `MSB_OFF_IRQ_MASK:   next_rdata = {7'h00, irq_mask};
      default:             next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Sticky interrupt status: set wins over read clear
  assign modem_evt = |next_delta;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_stat <= 1'h0;
    end else if (modem_evt) begin
      irq_stat <= 1'h1;
    end else if (rd_irq) begin
      irq_stat <= 1'h0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_o        <= 1'b0;
      divisor_o    <= 16'h0000;
      bank_o       <= MSB_BANK_GEN_E;
      lvl_access_o <= 1'b0;
      modem_ctrl_o <= 5'h00;
    end else begin
      irq_o        <= |(irq_stat & irq_mask) || (modem_evt && irq_mask[`MSB_IRQ_MODEM]);
      divisor_o    <= {divisor_high, divisor_low};
      bank_o       <= extra_feature_select.bank;
      lvl_access_o <= lvl_ok;
      modem_ctrl_o <= modem_control_reg;
    end
  end

endmodule : msb_regs
`default_nettype wire

/* File: rtl/msb_consts.svh */
// Register offsets, field positions and reset values of the modem status and bank select block
`ifndef MSB_CONSTS_SVH
`define MSB_CONSTS_SVH
`define MSB_ADDR_W          4
`define MSB_OFF_MODEM_STAT  4'h6
`define MSB_OFF_SCRATCH     4'h7
`define MSB_OFF_DIV_LOW     4'h0
`define MSB_OFF_DIV_HIGH    4'h1
`define MSB_OFF_TX_SPACE    4'h8
`define MSB_OFF_RX_FILL     4'h9
`define MSB_OFF_MCTRL       4'h4
`define MSB_OFF_IRQ_STAT    4'ha
`define MSB_OFF_IRQ_MASK    4'hb
`define MSB_BIT_CD          7
`define MSB_BIT_RI          6
`define MSB_BIT_DSR         5
`define MSB_BIT_CTS         4
`define MSB_BIT_DCD         3
`define MSB_BIT_TERI        2
`define MSB_BIT_DDSR        1
`define MSB_BIT_DCTS        0
`define MSB_MC_LOOP         4
`define MSB_MC_OUT2         3
`define MSB_MC_OUT1         2
`define MSB_MC_RTS          1
`define MSB_MC_DTR          0
`define MSB_SEL_LVL_EN      0
`define MSB_BANK_GENERAL    2'h0
`define MSB_BANK_EXTRA1     2'h1
`define MSB_BANK_EXTRA2     2'h2
`define MSB_RST_BYTE        8'h00
`define MSB_RST_MODEM_IN    4'hf
`define MSB_IRQ_MODEM       0
`endif

/* File: rtl/msb_pkg.sv */
// Types shared by the modem status and bank select block
package msb_pkg;
  typedef enum logic [1:0] {
    MSB_BANK_GEN_E = 2'h0,
    MSB_BANK_EX1_E = 2'h1,
    MSB_BANK_EX2_E = 2'h2,
    MSB_BANK_RSV_E = 2'h3
  } msb_bank_t;
  typedef struct packed {
    logic carrier_detect_n;
    logic ring_indicator_n;
    logic data_set_ready_n;
    logic clear_to_send_n;
  } msb_modem_t;
  typedef struct packed {
    logic [4:0] reserved;
    msb_bank_t  bank;
    logic       lvl_en;
  } msb_sel_t;
endpackage : msb_pkg

/* File: verif/msb_regs_asserts.sv */
// Port assertions of the modem status and bank select block
`timescale 1ns/1ps
`default_nettype none
module msb_regs_asserts
  import msb_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        srst_i,
  input wire logic [3:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire msb_modem_t  modem_n_i,
  input wire logic [7:0]  tx_space_i,
  input wire logic [15:0] divisor_o,
  input wire msb_bank_t   bank_o,
  input wire logic        lvl_access_o,
  input wire logic [4:0]  modem_ctrl_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  a_bank_write: assert property (wr_i && addr_i == 4'h6 |-> ##2 bank_o == $past(wdata_i[2:1], 2))
    else $error("bank field");
  a_lvl_enable: assert property (wr_i && addr_i == 4'h6 |-> ##2
    lvl_access_o == ($past(wdata_i[0], 2) && $past(wdata_i[2:1], 2) == 2'h0)) else $error("level enable");
  a_div_low: assert property (wr_i && addr_i == 4'h0 |-> ##2 divisor_o[7:0] == $past(wdata_i, 2))
    else $error("divisor low");
  a_div_high: assert property (wr_i && addr_i == 4'h1 |-> ##2 divisor_o[15:8] == $past(wdata_i, 2))
    else $error("divisor high");
  a_live_bits: assert property (rd_i && addr_i == 4'h6 && !modem_ctrl_o[4] |=>
    rdata_o[7:4] == ~$past(modem_n_i)) else $error("live bits");
  a_loop_bits: assert property (rd_i && addr_i == 4'h6 && modem_ctrl_o[4] |=>
    rdata_o[7:4] == $past({modem_ctrl_o[3:2], modem_ctrl_o[0], modem_ctrl_o[1]})) else $error("loop bits");
  a_tx_level: assert property (rd_i && addr_i == 4'h8 && lvl_access_o |=> rdata_o == $past(tx_space_i))
    else $error("tx level");
  a_lvl_off: assert property (rd_i && addr_i == 4'h8 && !lvl_access_o |=> rdata_o == 8'h00)
    else $error("level hidden");
endmodule : msb_regs_asserts
bind msb_regs msb_regs_asserts u_chk (.*);
`default_nettype wire

/* File: verif/msb_modem_model.sv */
// Modem pins and FIFO levels facing the register block
`timescale 1ns/1ps
`default_nettype none
module msb_modem_model
  import msb_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic [3:0] pins_i,
  input  wire logic [7:0] lvl_i,
  output var  msb_modem_t modem_n_o,
  output var  logic [7:0] tx_space_o,
  output var  logic [7:0] rx_fill_o
);
  always_ff @(posedge mclk_i) begin
    modem_n_o  <= pins_i;
    tx_space_o <= lvl_i;
    rx_fill_o  <= ~lvl_i;
  end
endmodule : msb_modem_model
`default_nettype wire

/* File: verif/msb_regs_tb_top.sv */
// Self-checking bench of the modem status and bank select block
`timescale 1ns/1ps
`default_nettype none
module msb_regs_tb_top;
  import msb_pkg::*;
  typedef struct {bit w; logic [3:0] a; logic [7:0] d;} msb_row_t;
  logic       mclk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, lvl_access_o, irq_o;
  logic [3:0] addr_i = 4'h0, pins = 4'hf;
  logic [7:0] wdata_i = 8'h00, rdata_o, tx_space_i, rx_fill_i;
  logic [15:0] divisor_o;
  logic [4:0] modem_ctrl_o;
  msb_bank_t  bank_o;
  msb_modem_t modem_n_i;
  int         errors = 0, total_checks = 0;
  msb_row_t   rows[14] = '{'{1,4'h7,8'h5a}, '{0,4'h7,8'h5a}, '{1,4'h0,8'h34}, '{1,4'h1,8'h12},
    '{0,4'h0,8'h34}, '{0,4'h1,8'h12}, '{1,4'h6,8'h01}, '{0,4'h8,8'h40}, '{0,4'h9,8'hbf},
    '{1,4'h6,8'h03}, '{0,4'h8,8'h00}, '{1,4'h6,8'h04}, '{0,4'h9,8'h00}, '{0,4'hc,8'h00}};
  msb_regs dut (.*);
  msb_modem_model u_modem (.mclk_i(mclk_i), .pins_i(pins), .lvl_i(8'h40), .modem_n_o(modem_n_i),
    .tx_space_o(tx_space_i), .rx_fill_o(rx_fill_i));
  initial forever #25 mclk_i = ~mclk_i;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input bit w, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= w;
    rd_i    <= !w;
    @(posedge mclk_i);
    wr_i <= 0;
    rd_i <= 0;
    #1;
    if (!w) check(rdata_o, d);
  endtask : bus
  task automatic pin_set(input logic [3:0] p);
    @(posedge mclk_i);
    pins <= p;
    repeat (4) @(posedge mclk_i);
  endtask : pin_set
  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial begin
    #100us;
    errors++;
    results();
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    srst_i <= 0;
    #1;
    check({5'h00, bank_o, irq_o}, 8'h00);
    foreach (rows[i]) bus(rows[i].w, rows[i].a, rows[i].d);
    bus(1, 4'hb, 8'h01);
    pin_set(4'h0);
    check({7'h00, irq_o}, 8'h01);
    bus(0, 4'h6, 8'hfb);
    bus(0, 4'h6, 8'hf0);
    bus(0, 4'ha, 8'h01);
    pin_set(4'hf);
    bus(0, 4'h6, 8'h0f);
    pin_set(4'he);
    pin_set(4'hf);
    bus(0, 4'h6, 8'h01);
    bus(1, 4'hb, 8'h00);
    bus(0, 4'ha, 8'h01);
    pin_set(4'hd);
    check({7'h00, irq_o}, 8'h00);
    pin_set(4'hf);
    bus(0, 4'h6, 8'h02);
    bus(1, 4'h4, 8'h1a);
    repeat (3) @(posedge mclk_i);
    check({3'h0, modem_ctrl_o}, 8'h1a);
    bus(0, 4'h6, 8'h99);
    results();
  end
endmodule : msb_regs_tb_top
`default_nettype wire
